// >>> design/result_buffer_pkg.sv
package result_buffer_pkg;
    // ------------------------------------------------------------
    // buffer geometry
    // ------------------------------------------------------------
    localparam int DEPTH = 128;
    localparam int IDX_W = 7;
    localparam logic [IDX_W:0] CAPACITY = 8'h80;
    localparam logic [IDX_W-1:0] LAST_IDX = 7'h7f;
    localparam logic [IDX_W-1:0] IDX_ONE = 7'h01;
    localparam logic [IDX_W:0] CNT_ONE = 8'h01;

    // ------------------------------------------------------------
    // filler values for unused slots, plus the neutral verdict for judgement off
    // ------------------------------------------------------------
    localparam logic [63:0] FILL_REAL = $realtobits(9.9e37);
    localparam logic [7:0] FILL_STATUS = 8'hff;
    localparam logic [7:0] FILL_BIN = 8'h00;
    localparam logic [7:0] ZERO_VERDICT = 8'h00;

    // ------------------------------------------------------------
    // error codes for the two error pulses; no port carries them
    // ------------------------------------------------------------
    localparam logic signed [15:0] ERR_OVERFLOW = 16'sh005a;
    localparam logic signed [15:0] ERR_QUERY_INT = -16'sh019a;

    // ------------------------------------------------------------
    // status byte bit positions
    // ------------------------------------------------------------
    localparam int STB_OPER = 7;
    localparam int STB_RQS = 6;
    localparam int STB_STD = 5;
    localparam int STB_MAV = 4;
    localparam logic [7:0] SRE_MASK_NO_RQS = 8'hbf;

    // one finished measurement as delivered by the measuring engine
    typedef struct packed {
        logic [63:0] primary;
        logic [63:0] secondary;
        logic [7:0] meas_status;
        logic [7:0] verdict;
        logic is_list;
        logic judge_on;
    } result_in_t;

    // one stored result set
    typedef struct packed {
        logic [63:0] primary;
        logic [63:0] secondary;
        logic [7:0] meas_status;
        logic [7:0] verdict;
    } result_set_t;

    // reader state
    typedef enum logic [1:0] {
        RD_IDLE = 2'b01,
        RD_SEND = 2'b10
    } rd_state_t;
endpackage : result_buffer_pkg

// >>> design/result_buffer_status_byte.sv
`timescale 1ns/1ns
module result_buffer_status_byte (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // remote commands, one-cycle strobes, plus the fmt_ascii level
    input wire logic buffer_fill_cmd,
    input wire logic buffer_clear_cmd,
    input wire logic buffer_read_query,
    input wire logic fmt_ascii,
    // measurement engine
    input wire logic meas_done,
    input wire logic meas_by_common,
    input wire result_buffer_pkg::result_in_t meas_result,
    // output buffer handshake
    input wire logic outbuf_read,
    // status sources and enables
    input wire logic oper_event_any,
    input wire logic std_event_any,
    input wire logic [7:0] srq_enable,
    input wire logic serial_poll,
    input wire logic stb_query,
    // buffer read response stream
    output result_buffer_pkg::result_set_t resp_set,
    output logic resp_valid,
    output logic resp_first,
    output logic resp_last,
    output logic resp_ascii,
    // output buffer
    output result_buffer_pkg::result_set_t outbuf_set,
    output logic outbuf_valid,
    // errors and events
    output logic err_overflow,
    output logic err_query_int,
    output logic esr_bit3_set,
    // status byte
    output logic [7:0] poll_byte,
    output logic poll_valid,
    output logic [7:0] stb_byte,
    output logic stb_valid,
    output logic srq
);
    import result_buffer_pkg::*;

    // ------------------------------------------------------------
    // storage and state
    // ------------------------------------------------------------
    result_set_t mem [DEPTH];
    logic [IDX_W:0] count_q;
    logic fill_q;
    rd_state_t rd_state_q;
    logic [IDX_W-1:0] rd_idx_q;
    result_set_t resp_set_q;
    logic resp_valid_q, resp_first_q, resp_last_q, resp_ascii_q;
    result_set_t outbuf_set_q;
    logic outbuf_valid_q;
    logic err_overflow_q, err_query_int_q, esr_bit3_q;
    logic [7:0] poll_byte_q, stb_byte_q;
    logic poll_valid_q, stb_valid_q;
    logic rqs_q;
    logic [7:0] summ_prev_q;

    result_set_t incoming;
    logic store_ok, store_drop, read_start;
    logic [7:0] summ;
    logic mss;
    logic rqs_rise;

    // ------------------------------------------------------------
    // incoming result shaping
    // ------------------------------------------------------------
    // the engine reports each sweep point separately, repeats included
    always_comb begin
        incoming.primary = meas_result.primary;
        incoming.secondary = meas_result.secondary;
        incoming.meas_status = meas_result.meas_status;
        // judgement off forces a neutral verdict or bin
        incoming.verdict = meas_result.judge_on ? meas_result.verdict : ZERO_VERDICT;
    end

    // store while filling and room is left, drop otherwise
    assign store_ok = fill_q && meas_done && (count_q < CAPACITY);
    assign store_drop = fill_q && meas_done && (count_q == CAPACITY);
    assign read_start = buffer_read_query && (rd_state_q == RD_IDLE);

    // ------------------------------------------------------------
    // fill mode and write position
    // ------------------------------------------------------------
    // no interlock against filling on top of old data; that is software's job
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fill_q <= 1'b0;
        end else if (buffer_fill_cmd) begin
            fill_q <= 1'b1;
        end
    end

    // clear wins over a store in the same cycle so the next fill starts at slot 0
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            count_q <= '0;
        end else if (buffer_clear_cmd) begin
            count_q <= '0;
        end else if (store_ok) begin
            count_q <= count_q + CNT_ONE;
        end
    end

    // memory array, no reset needed: count gates every read
    always_ff @(posedge clk) begin
        if (store_ok && !buffer_clear_cmd) begin
            mem[count_q[IDX_W-1:0]] <= incoming;
        end
    end

    // ------------------------------------------------------------
    // buffer read response
    // ------------------------------------------------------------
    // all 128 slots go out back to back, one set per cycle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rd_state_q <= RD_IDLE;
            rd_idx_q <= '0;
        end else begin
            case (rd_state_q)
                RD_IDLE: begin
                    if (read_start) begin
                        rd_state_q <= RD_SEND;
                        rd_idx_q <= '0;
                    end
                end
                RD_SEND: begin
                    rd_idx_q <= rd_idx_q + IDX_ONE;
                    if (rd_idx_q == LAST_IDX) begin
                        rd_state_q <= RD_IDLE;
                    end
                end
                default: begin
                    rd_state_q <= RD_IDLE;
                end
            endcase
        end
    end

    // registered stream stage, filler for slots at or above the stored count
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            resp_valid_q <= 1'b0;
            resp_first_q <= 1'b0;
            resp_last_q <= 1'b0;
            resp_set_q <= '0;
        end else begin
            resp_valid_q <= (rd_state_q == RD_SEND);
            resp_first_q <= (rd_state_q == RD_SEND) && (rd_idx_q == '0);
            resp_last_q <= (rd_state_q == RD_SEND) && (rd_idx_q == LAST_IDX);
            if ({1'b0, rd_idx_q} < count_q) begin
                resp_set_q <= mem[rd_idx_q];
            end else begin
                resp_set_q <= '{FILL_REAL, FILL_REAL, FILL_STATUS, FILL_BIN};
            end
        end
    end

    // format is frozen per response so a mid-stream change cannot split it
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            resp_ascii_q <= 1'b0;
        end else if (read_start) begin
            resp_ascii_q <= fmt_ascii;
        end
    end

    // ------------------------------------------------------------
    // output buffer for common and group-execute triggers
    // ------------------------------------------------------------
    // a new result wins over a read in the same cycle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            outbuf_valid_q <= 1'b0;
            outbuf_set_q <= '0;
        end else if (meas_done && meas_by_common) begin
            outbuf_valid_q <= 1'b1;
            outbuf_set_q <= incoming;
        end else if (outbuf_read) begin
            outbuf_valid_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // error pulses
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            err_query_int_q <= 1'b0;
            err_overflow_q <= 1'b0;
            esr_bit3_q <= 1'b0;
        end else begin
            // immediate triggers never touch the output buffer
            err_query_int_q <= meas_done && meas_by_common && outbuf_valid_q
                && !outbuf_read;
            err_overflow_q <= store_drop && !buffer_clear_cmd;
            esr_bit3_q <= store_drop && !buffer_clear_cmd;
        end
    end

    // ------------------------------------------------------------
    // status byte and service request
    // ------------------------------------------------------------
    // low nibble always zero; bit 6 is filled when the byte is polled or queried
    always_comb begin
        summ = '0;
        summ[STB_OPER] = oper_event_any;
        summ[STB_STD] = std_event_any;
        summ[STB_MAV] = outbuf_valid_q || (rd_state_q == RD_SEND);
        mss = |(summ & srq_enable & SRE_MASK_NO_RQS);
        rqs_rise = |(summ & ~summ_prev_q & srq_enable & SRE_MASK_NO_RQS);
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            summ_prev_q <= '0;
        end else begin
            summ_prev_q <= summ;
        end
    end

    // a new request beats the clear of a poll in the same cycle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rqs_q <= 1'b0;
        end else if (rqs_rise) begin
            rqs_q <= 1'b1;
        end else if (serial_poll) begin
            rqs_q <= 1'b0;
        end
    end

    // poll shows the request flag, the query shows master summary
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            poll_byte_q <= '0;
            poll_valid_q <= 1'b0;
            stb_byte_q <= '0;
            stb_valid_q <= 1'b0;
        end else begin
            poll_valid_q <= serial_poll;
            stb_valid_q <= stb_query;
            if (serial_poll) begin
                poll_byte_q <= summ | ({7'h00, rqs_q} << STB_RQS);
            end
            if (stb_query) begin
                stb_byte_q <= summ | ({7'h00, mss} << STB_RQS);
            end
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign resp_set = resp_set_q;
    assign resp_valid = resp_valid_q;
    assign resp_first = resp_first_q;
    assign resp_last = resp_last_q;
    assign resp_ascii = resp_ascii_q;
    assign outbuf_set = outbuf_set_q;
    assign outbuf_valid = outbuf_valid_q;
    assign err_overflow = err_overflow_q;
    assign err_query_int = err_query_int_q;
    assign esr_bit3_set = esr_bit3_q;
    assign poll_byte = poll_byte_q;
    assign poll_valid = poll_valid_q;
    assign stb_byte = stb_byte_q;
    assign stb_valid = stb_valid_q;
    assign srq = rqs_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_count_bound: assert property (@(posedge clk) disable iff (!nrst)
        count_q <= CAPACITY) else $error("buffer count above capacity");
    a_resp_length: assert property (@(posedge clk) disable iff (!nrst)
        $rose(resp_first) |-> resp_valid [*8]) else $error("response broke early");
    a_resp_end: assert property (@(posedge clk) disable iff (!nrst)
        resp_first |-> ##127 resp_last) else $error("response not 128 sets");
    a_store_order: assert property (@(posedge clk) disable iff (!nrst)
        store_ok && !buffer_clear_cmd |=> count_q == $past(count_q) + CNT_ONE)
        else $error("store did not advance");
    a_imm_no_outbuf: assert property (@(posedge clk) disable iff (!nrst)
        meas_done && !meas_by_common && !outbuf_valid_q |=> !outbuf_valid)
        else $error("immediate result reached output buffer");
    a_common_outbuf: assert property (@(posedge clk) disable iff (!nrst)
        meas_done && meas_by_common |=> outbuf_valid && outbuf_set == $past(incoming))
        else $error("common result missing from output buffer");
    a_query_int: assert property (@(posedge clk) disable iff (!nrst)
        meas_done && meas_by_common && outbuf_valid && !outbuf_read |=> err_query_int)
        else $error("missing query interrupted error");
    a_overflow: assert property (@(posedge clk) disable iff (!nrst)
        store_drop && !buffer_clear_cmd |=> err_overflow && esr_bit3_set
        && count_q == CAPACITY) else $error("overflow not flagged");
    a_filler: assert property (@(posedge clk) disable iff (!nrst)
        rd_state_q == RD_SEND && {1'b0, rd_idx_q} >= count_q
        |=> resp_set.meas_status == FILL_STATUS && resp_set.primary == FILL_REAL)
        else $error("unused slot not filled");
    a_poll_clears: assert property (@(posedge clk) disable iff (!nrst)
        serial_poll && !rqs_rise |=> !srq) else $error("poll left request set");
    a_stb_keeps: assert property (@(posedge clk) disable iff (!nrst)
        stb_query && !serial_poll && !rqs_rise |=> srq == $past(rqs_q))
        else $error("status query altered request flag");
    a_poll_value: assert property (@(posedge clk) disable iff (!nrst)
        serial_poll |=> poll_byte[3:0] == 4'h0 && poll_byte[STB_MAV] == $past(summ[STB_MAV])
        && poll_byte[STB_OPER] == $past(oper_event_any)) else $error("poll byte wrong");
    a_clear_reset: assert property (@(posedge clk) disable iff (!nrst)
        buffer_clear_cmd |=> count_q == '0) else $error("clear did not empty buffer");
endmodule : result_buffer_status_byte

// >>> sim/controller_model.sv
`timescale 1ns/1ns
// ----------------------------------------
// remote controller, output buffer reader
// ----------------------------------------
module controller_model (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // output buffer side
    input wire logic outbuf_valid,
    input wire logic [3:0] read_lag,
    output logic outbuf_read
);
    logic [3:0] wait_q;

    // reads each result read_lag + 1 cycles after it appears; lag 4'hf
    // never reads, so a scenario can make the controller fall behind
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wait_q <= 4'h0;
            outbuf_read <= 1'b0;
        end else if (outbuf_read) begin
            outbuf_read <= 1'b0;
            wait_q <= 4'h0;
        end else if (outbuf_valid && read_lag != 4'hf) begin
            outbuf_read <= (wait_q >= read_lag);
            wait_q <= wait_q + 4'h1;
        end
    end
endmodule : controller_model

// >>> sim/result_buffer_status_byte_tb.sv
`timescale 1ns/1ns
module result_buffer_status_byte_tb;
    import result_buffer_pkg::*;

    localparam result_set_t FILLER = '{FILL_REAL, FILL_REAL, FILL_STATUS, FILL_BIN};

    logic clk, nrst, buffer_fill_cmd, buffer_clear_cmd, buffer_read_query, fmt_ascii;
    logic meas_done, meas_by_common, outbuf_read, oper_event_any, std_event_any;
    logic serial_poll, stb_query, resp_valid, resp_first, resp_last, resp_ascii;
    logic outbuf_valid, err_overflow, err_query_int, esr_bit3_set, poll_valid, stb_valid, srq;
    logic [7:0] srq_enable, poll_byte, stb_byte;
    logic [3:0] read_lag;
    result_in_t meas_result;
    result_set_t resp_set, outbuf_set;
    result_set_t exp_q[$];
    int n_errors, samples_checked, n_ovf, n_qint, n_esr;

    result_buffer_status_byte i_result_buffer_status_byte (
        .clk(clk), .nrst(nrst), .buffer_fill_cmd(buffer_fill_cmd),
        .buffer_clear_cmd(buffer_clear_cmd), .buffer_read_query(buffer_read_query),
        .fmt_ascii(fmt_ascii), .meas_done(meas_done), .meas_by_common(meas_by_common),
        .meas_result(meas_result), .outbuf_read(outbuf_read),
        .oper_event_any(oper_event_any), .std_event_any(std_event_any),
        .srq_enable(srq_enable), .serial_poll(serial_poll), .stb_query(stb_query),
        .resp_set(resp_set), .resp_valid(resp_valid), .resp_first(resp_first),
        .resp_last(resp_last), .resp_ascii(resp_ascii), .outbuf_set(outbuf_set),
        .outbuf_valid(outbuf_valid), .err_overflow(err_overflow),
        .err_query_int(err_query_int), .esr_bit3_set(esr_bit3_set),
        .poll_byte(poll_byte), .poll_valid(poll_valid), .stb_byte(stb_byte),
        .stb_valid(stb_valid), .srq(srq)
    );

    controller_model i_controller_model (
        .clk(clk), .nrst(nrst), .outbuf_valid(outbuf_valid),
        .read_lag(read_lag), .outbuf_read(outbuf_read)
    );

    // 100 ns clock
    always #50 clk = ~clk;

    // count error pulses, each one cycle wide
    always @(negedge clk) begin
        if (err_overflow === 1'b1) n_ovf++;
        if (err_query_int === 1'b1) n_qint++;
        if (esr_bit3_set === 1'b1) n_esr++;
    end

    // ----------------------------------------
    // access tasks
    // ----------------------------------------
    task automatic check(input string what, input logic [159:0] seen, input logic [159:0] e);
        samples_checked++;
        if (seen !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, e, seen);
        end
    endtask : check

    task automatic test_done;
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : test_done

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    // one-cycle strobe: 0 fill, 1 clear, 2 poll, 3 status query, 4 read
    task automatic cmd(input int c);
        tick(1);
        case (c)
            0: buffer_fill_cmd <= 1'b1;
            1: buffer_clear_cmd <= 1'b1;
            2: serial_poll <= 1'b1;
            3: stb_query <= 1'b1;
            default: buffer_read_query <= 1'b1;
        endcase
        tick(1);
        {buffer_fill_cmd, buffer_clear_cmd, serial_poll, stb_query, buffer_read_query} <= 5'h0;
    endtask : cmd

    // meas_done stays high across calls, so calls in a row are back to back
    task automatic measure(input logic com, input logic [63:0] p, input logic [7:0] v,
                           input logic judge, input logic lst);
        tick(1);
        meas_done <= 1'b1;
        meas_by_common <= com;
        meas_result <= '{p, ~p, p[7:0], v, lst, judge};
        if (exp_q.size() < DEPTH) exp_q.push_back({p, ~p, p[7:0], judge ? v : ZERO_VERDICT});
    endtask : measure

    task automatic meas_end;
        tick(1);
        meas_done <= 1'b0;
        repeat (3) @(negedge clk);
    endtask : meas_end

    task automatic stat_chk(input int c, input logic [7:0] e);
        cmd(c);
        @(negedge clk);
        if (c == 2) check("poll_byte", {poll_valid, poll_byte}, {1'b1, e});
        else check("stb_byte", {stb_valid, stb_byte}, {1'b1, e});
    endtask : stat_chk

    // whole response of one query, every slot in one burst
    task automatic read_all(input logic asc);
        int n;
        n = 0;
        tick(1);
        fmt_ascii <= asc;
        cmd(4);
        while (resp_valid !== 1'b1) begin
            @(negedge clk);
            n++;
            if (n > 6) begin
                n_errors++;
                test_done();
            end
        end
        for (int i = 0; i < DEPTH; i++) begin
            check("resp_set", resp_set, (i < exp_q.size()) ? exp_q[i] : FILLER);
            check("resp_flags", {resp_valid, resp_first, resp_last, resp_ascii},
                  {1'b1, i == 0, i == DEPTH - 1, asc});
            @(negedge clk);
        end
        check("resp_end", resp_valid, 1'b0);
    endtask : read_all

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {clk, nrst, buffer_fill_cmd, buffer_clear_cmd, buffer_read_query, fmt_ascii} = '0;
        {meas_done, meas_by_common, oper_event_any, std_event_any, serial_poll} = '0;
        {stb_query, srq_enable, read_lag} = '0;
        meas_result = '0;
        {n_errors, samples_checked, n_ovf, n_qint, n_esr} = '0;
        tick(5);
        nrst <= 1'b1;
        read_all(1'b0);
        stat_chk(2, 8'h00);
        // clear first, then fill; immediate triggers stay out of the output buffer
        cmd(1);
        cmd(0);
        measure(1'b0, 64'h1, 8'h05, 1'b1, 1'b0);
        measure(1'b0, 64'h2, 8'h07, 1'b0, 1'b1);
        measure(1'b0, 64'h2, 8'h07, 1'b1, 1'b1);
        meas_end();
        check("outbuf_valid", outbuf_valid, 1'b0);
        read_all(1'b1);
        // prompt controller: result lands in both buffers, no error
        measure(1'b1, 64'h3, 8'h09, 1'b1, 1'b0);
        tick(1);
        meas_done <= 1'b0;
        @(negedge clk);
        check("outbuf", {outbuf_valid, outbuf_set}, {1'b1, exp_q[3]});
        repeat (4) @(negedge clk);
        check("qint_none", {outbuf_valid, 144'(n_qint)}, 145'h0);
        // stalled controller: second result overruns the unread one
        tick(1);
        srq_enable <= 8'h10;
        read_lag <= 4'hf;
        measure(1'b1, 64'h4, 8'h00, 1'b1, 1'b0);
        measure(1'b1, 64'h5, 8'h00, 1'b1, 1'b0);
        meas_end();
        check("qint", 144'(n_qint), 144'h1);
        check("srq_mav", srq, 1'b1);
        stat_chk(3, 8'h50);
        check("srq_kept", srq, 1'b1);
        stat_chk(2, 8'h50);
        @(negedge clk);
        check("srq_polled", srq, 1'b0);
        stat_chk(2, 8'h10);
        tick(1);
        read_lag <= 4'h0;
        repeat (4) @(negedge clk);
        stat_chk(2, 8'h00);
        // summary bits; bit 6 of the enable mask is ignored
        tick(1);
        srq_enable <= 8'he0;
        tick(1);
        oper_event_any <= 1'b1;
        tick(2);
        std_event_any <= 1'b1;
        repeat (3) @(negedge clk);
        check("srq_evt", srq, 1'b1);
        stat_chk(2, 8'he0);
        stat_chk(2, 8'ha0);
        tick(1);
        srq_enable <= 8'h00;
        stat_chk(3, 8'ha0);
        tick(1);
        oper_event_any <= 1'b0;
        stat_chk(3, 8'h20);
        tick(1);
        std_event_any <= 1'b0;
        stat_chk(3, 8'h00);
        read_all(1'b0);
        // overflow: 129 sets back to back, the last one is dropped
        cmd(1);
        exp_q.delete();
        for (int i = 0; i < DEPTH + 1; i++) measure(1'b0, 64'(i + 16), 8'h01, 1'b1, 1'b0);
        meas_end();
        check("ovf", 144'(n_ovf), 144'h1);
        check("esr_bit3", 144'(n_esr), 144'h1);
        read_all(1'b1);
        // after clear, writing starts again at slot zero
        cmd(1);
        exp_q.delete();
        measure(1'b0, 64'h77, 8'h02, 1'b1, 1'b0);
        meas_end();
        read_all(1'b0);
        test_done();
    end
endmodule : result_buffer_status_byte_tb
